// File: rtl/rcj_fifo.sv
`timescale 1ns/1ps
module rcj_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] rd_r;
    wire full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    wire empty = (wr_r == rd_r);
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_r[rd_r[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_r <= '0;
            rd_r <= '0;
        end else if (clear) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
        end
    end
endmodule

// File: rtl/rcj_pkg.sv
package rcj_pkg;
    // bit timing derived from the system clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_TIME_NS = 100;
    localparam int BIT_CYC = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_CYC = BIT_CYC / 2;
    // lengths in bit times, then counter widths and buffer depth
    localparam int JAM_BITS = 96;
    localparam int GAP_BITS = 96;
    localparam int ALT_BITS = 62;
    localparam int CNT_W = 7;
    localparam int DIV_W = 4;
    localparam int FIFO_DEPTH = 16;
    // reset values
    localparam logic RST_LINE = 1'b0;
    localparam logic RST_PHASE = 1'b1;

    typedef enum logic [4:0] {
        RCJ_IDLE = 5'h01,
        RCJ_REPEAT = 5'h02,
        RCJ_RXCOL = 5'h04,
        RCJ_TXCOL = 5'h08,
        RCJ_GAP = 5'h10
    } rcj_state_type;
endpackage

// File: rtl/rcj_repeater.sv
`timescale 1ns/1ps
module rcj_repeater
    import rcj_pkg::*;
#(
    parameter int PORTS = 4,
    parameter int DEPTH = rcj_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [PORTS-1:0] rx_active,
    input wire logic [PORTS-1:0] rx_data,
    input wire logic [PORTS-1:0] col_in,
    output logic rx_ready,
    output logic [PORTS-1:0] do_line,
    output logic [PORTS-1:0] do_active,
    output logic jam_active
);
    import rcj_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // bit and half-bit enables
    logic [DIV_W-1:0] div_r;
    wire bit_tick = (div_r == '0);
    wire mid_tick = (div_r == DIV_W'(HALF_CYC));
    wire [DIV_W-1:0] div_nxt = (div_r == DIV_W'(BIT_CYC - 1)) ? '0
                                                               : div_r + 1'b1;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port decode
    rcj_state_type st_r, st_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [PORTS-1:0] src_r, src_nxt;
    logic ph_r, ph_nxt;
    logic tx_bit_r, tx_bit_nxt;
    logic tx_on_nxt;
    logic [PORTS-1:0] mask_nxt;
    logic [PORTS-1:0] line_r;
    logic [PORTS-1:0] act_r;
    logic pop;

    wire [PORTS-1:0] busy = rx_active | col_in;
    wire none_busy = (busy == '0);
    wire one_active = (rx_active != '0)
                      && ((rx_active & (rx_active - 1'b1)) == '0);
    wire others_busy = ((busy & ~src_r) != '0);
    wire src_col = ((col_in & src_r) != '0);
    wire src_on = ((rx_active & src_r) != '0);
    wire src_bit = ((rx_data & src_r) != '0);
    wire jam_done = (cnt_r >= CNT_W'(JAM_BITS - 1));
    wire gap_done = (cnt_r >= CNT_W'(GAP_BITS - 1));
    // saturates so a long collision cannot wrap
    wire [CNT_W-1:0] cnt_inc = (cnt_r == '1) ? cnt_r : cnt_r + 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // elastic bit buffer between the receiving port and the senders
    wire fifo_clr = (st_r == RCJ_IDLE) || (st_r == RCJ_TXCOL)
                    || (st_r == RCJ_GAP);
    // preamble, less its first bit, and delimiter pass through the buffer unchanged
    wire fifo_wr = bit_tick && src_on
                   && ((st_r == RCJ_REPEAT) || (st_r == RCJ_RXCOL));
    wire fifo_valid;
    wire fifo_bit;

    rcj_fifo #(
        .WIDTH(1),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .clear(fifo_clr),
        .in_valid(fifo_wr),
        .in_ready(rx_ready),
        .in_data(src_bit),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_bit)
    );

    ////////////////////////////////////////////////////////////////////////
    // repeater sequencing, evaluated once per bit time
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        src_nxt = src_r;
        ph_nxt = ~ph_r;
        tx_bit_nxt = 1'b0;
        tx_on_nxt = 1'b0;
        mask_nxt = ~src_r;
        pop = 1'b0;
        unique case (st_r)
            RCJ_IDLE: begin
                // the bit seen while deciding is not buffered
                ph_nxt = RST_PHASE;
                if (!none_busy && (!one_active || col_in != '0)) begin
                    st_nxt = RCJ_TXCOL;
                    cnt_nxt = '0;
                end else if (one_active) begin
                    st_nxt = RCJ_REPEAT;
                    src_nxt = rx_active;
                    cnt_nxt = '0;
                end
            end
            RCJ_REPEAT: begin
                if (fifo_valid) begin
                    tx_on_nxt = 1'b1;
                    tx_bit_nxt = fifo_bit;
                    pop = bit_tick;
                    cnt_nxt = cnt_inc;
                end
                if (others_busy) begin
                    st_nxt = RCJ_TXCOL;
                    cnt_nxt = '0;
                    ph_nxt = RST_PHASE;
                end else if (src_col) begin
                    st_nxt = RCJ_RXCOL;
                    ph_nxt = RST_PHASE;
                end else if (!src_on && !fifo_valid) begin
                    st_nxt = RCJ_GAP;
                    cnt_nxt = '0;
                end
            end
            RCJ_RXCOL: begin
                // buffered data first, then jam up to the minimum length
                tx_on_nxt = 1'b1;
                tx_bit_nxt = fifo_valid ? fifo_bit : ph_r;
                pop = bit_tick && fifo_valid;
                cnt_nxt = cnt_inc;
                if (others_busy) begin
                    st_nxt = RCJ_TXCOL;
                    cnt_nxt = '0;
                    ph_nxt = RST_PHASE;
                end else if (jam_done && !src_on && !src_col) begin
                    st_nxt = RCJ_GAP;
                    cnt_nxt = '0;
                end
            end
            RCJ_TXCOL: begin
                // first bit one, alternating from there on
                tx_on_nxt = 1'b1;
                tx_bit_nxt = ph_r;
                mask_nxt = '1;
                cnt_nxt = cnt_inc;
                if (jam_done && none_busy) begin
                    st_nxt = RCJ_GAP;
                    cnt_nxt = '0;
                end
            end
            RCJ_GAP: begin
                // receive bits refused here, buffer held clear
                cnt_nxt = cnt_inc;
                if (gap_done) begin
                    st_nxt = RCJ_IDLE;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= RCJ_IDLE;
            cnt_r <= '0;
            src_r <= '0;
            ph_r <= RST_PHASE;
            tx_bit_r <= 1'b0;
        end else begin
            if (bit_tick) begin
                st_r <= st_nxt;
                cnt_r <= cnt_nxt;
                src_r <= src_nxt;
                ph_r <= ph_nxt;
                tx_bit_r <= tx_bit_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // manchester encoder driving every enabled port
    wire [PORTS-1:0] act_nxt = mask_nxt & {PORTS{tx_on_nxt}};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            line_r <= {PORTS{RST_LINE}};
            act_r <= '0;
        end else if (bit_tick) begin
            act_r <= act_nxt;
            line_r <= act_nxt & {PORTS{~tx_bit_nxt}};
        end else if (mid_tick) begin
            line_r <= act_r & {PORTS{tx_bit_r}};
        end
    end

    assign do_line = line_r;
    assign do_active = act_r;
    // collision states, whichever side caused them
    assign jam_active = (st_r == RCJ_TXCOL) || (st_r == RCJ_RXCOL);
endmodule

// File: verif/rcj_mau.sv
`timescale 1ns/1ps
module rcj_mau #(
    parameter int PORTS = 4,
    // 20 ms of activity, 0.25 s of quiet, at a 10 ns clock
    parameter int JAB_CYC = 32'h001E8480,
    parameter int QUIET_CYC = 32'h017D7840
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [PORTS-1:0] do_active,
    input wire logic [PORTS-1:0] start_mask,
    input wire logic [7:0] nbits,
    input wire logic [7:0] col_bit,
    output logic busy,
    output logic [PORTS-1:0] rx_active,
    output logic [PORTS-1:0] rx_data,
    output logic [PORTS-1:0] col_in
);
    logic [3:0] ph_r;
    logic [7:0] pos_r;
    logic [7:0] len_r;
    logic [PORTS-1:0] mask_r;
    logic [PORTS-1:0] jab_r;
    logic [24:0] run_r [PORTS];
    assign busy = pos_r != len_r;
    assign rx_active = mask_r & {PORTS{busy}};
    // alternating preamble, delimiter ends in two ones
    assign rx_data = {PORTS{~pos_r[0] | (pos_r == 8'h3F)}};
    // collision level held to the end of the station's jam, or jabber
    assign col_in = (rx_active & {PORTS{pos_r >= col_bit}})
                    | jab_r;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ph_r <= 4'h0;
            pos_r <= 8'h00;
            len_r <= 8'h00;
            mask_r <= '0;
        end else begin
            ph_r <= (ph_r == 4'h9) ? 4'h0 : ph_r + 4'h1;
            if (ph_r == 4'h0 && busy) begin
                pos_r <= pos_r + 8'h01;
            end else if (ph_r == 4'h0 && start_mask != '0) begin
                mask_r <= start_mask;
                // frame tail stands for the station's check field
                len_r <= nbits;
                pos_r <= 8'h00;
            end
        end
    end
    // jabber: run of activity, or of quiet while jabbering
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            jab_r <= '0;
            for (int i = 0; i < PORTS; i++) begin
                run_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < PORTS; i++) begin
                if (run_r[i] >= (jab_r[i] ? QUIET_CYC : JAB_CYC)) begin
                    jab_r[i] <= ~jab_r[i];
                    run_r[i] <= '0;
                end else if (do_active[i] != jab_r[i]) begin
                    run_r[i] <= run_r[i] + 25'h1;
                end else begin
                    run_r[i] <= '0;
                end
            end
        end
    end
endmodule

// File: verif/rcj_repeater_tb_top.sv
`timescale 1ns/1ps
module rcj_repeater_tb_top;
    import rcj_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] start_mask = 4'h0;
    logic [7:0] nbits = 8'h00;
    logic [7:0] col_bit = 8'hFF;
    logic busy, rx_ready, jam_active;
    logic [3:0] rx_active, rx_data, col_in, do_line, do_active;
    int err_count = 0;
    int checks = 0;
    int n;
    time t_fall;
    always #5 clk = ~clk;
    rcj_repeater i_rcj_repeater (.clk(clk), .resetn(resetn),
        .rx_active(rx_active), .rx_data(rx_data), .col_in(col_in),
        .rx_ready(rx_ready), .do_line(do_line), .do_active(do_active),
        .jam_active(jam_active));
    rcj_mau i_rcj_mau (.clk(clk), .resetn(resetn), .start_mask(start_mask),
        .nbits(nbits), .col_bit(col_bit), .busy(busy),
        .rx_active(rx_active), .rx_data(rx_data), .col_in(col_in),
        .do_active(do_active));
    task chk(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task end_of_test;
        if (err_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task frame(logic [3:0] m, logic [7:0] len, logic [7:0] c);
        @(posedge clk);
        start_mask <= m;
        nbits <= len;
        col_bit <= c;
        repeat (40) begin
            @(negedge clk);
            if (busy === 1'b1)
                break;
        end
        @(posedge clk);
        start_mask <= 4'h0;
    endtask
    // counts cycles until port activity reaches the wanted level
    task wait_on(logic want);
        n = 0;
        while ((|do_active) !== want && n < 4000) begin
            @(negedge clk);
            n++;
        end
        if (!want)
            t_fall = $time;
    endtask
    task t_repeat;
        frame(4'h1, 8'd72, 8'hFF);
        wait_on(1'b1);
        chk("repeat ports", do_active, 4'hE);
        chk("buffer ready", rx_ready, 1'b1);
        // first bit goes to carrier detection, so the first cell is a zero
        chk("first half", do_line[1], 1'b1);
        repeat (5) @(negedge clk);
        chk("second half", do_line[1], 1'b0);
        chk("repeat jam", jam_active, 1'b0);
        wait_on(1'b0);
        chk("frame bits", (n + 5) / 10, 71);
    endtask
    task t_txcol;
        frame(4'h3, 8'd200, 8'hFF);
        wait_on(1'b1);
        chk("gap", ($time - t_fall) >= GAP_BITS * BIT_CYC * 10, 1);
        chk("jam ports", do_active, 4'hF);
        chk("jam flag", jam_active, 1'b1);
        chk("jam first", do_line, 4'h0);
        wait_on(1'b0);
        chk("jam bits", n >= JAM_BITS * BIT_CYC, 1);
    endtask
    task t_rxcol;
        frame(4'h1, 8'd152, 8'd120);
        wait_on(1'b1);
        chk("rxcol ports", do_active, 4'hE);
        repeat (300) @(negedge clk);
        chk("rxcol jam", jam_active, 1'b1);
        wait_on(1'b0);
        chk("rxcol bits", n + 300 >= JAM_BITS * BIT_CYC, 1);
    endtask
    initial begin
        #200000;
        err_count++;
        end_of_test;
    end
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_repeat;
        t_txcol;
        t_rxcol;
        end_of_test;
    end
endmodule

// File: verif/rcj_sva.sv
`timescale 1ns/1ps
module rcj_sva
    import rcj_pkg::*;
#(
    parameter int PORTS = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [PORTS-1:0] rx_active,
    input wire logic [PORTS-1:0] do_line,
    input wire logic [PORTS-1:0] do_active,
    input wire logic jam_active
);
    localparam int GAP_CYC = GAP_BITS * BIT_CYC;
    localparam int JAM_CYC = JAM_BITS * BIT_CYC;
    logic [3:0] ph_r;
    logic [11:0] idle_r;
    logic [11:0] all_r;
    logic seen_r;
    wire all_on = &do_active;
    wire any_on = |do_active;
    // bit phase, 0 at each bit tick
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ph_r <= 4'h0;
            idle_r <= 12'h000;
            all_r <= 12'h000;
            seen_r <= 1'b0;
        end else begin
            ph_r <= (ph_r == 4'h9) ? 4'h0 : ph_r + 4'h1;
            idle_r <= any_on ? 12'h000 : idle_r + {11'h000, ~&idle_r};
            all_r <= all_on ? all_r + {11'h000, ~&all_r} : 12'h000;
            seen_r <= seen_r | any_on;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence first_cell_s;
        do_line == '0 ##5 do_line == '1;
    endsequence
    idle_line_a: assert property ((do_line & ~do_active) == '0)
        else $error("line high on idle port");
    cell_mid_a: assert property (ph_r == 4'h6 |->
        ((do_line ^ $past(do_line)) & do_active) == do_active)
        else $error("no mid-cell transition");
    bit_stand_a: assert property ($changed(do_active) |-> ph_r == 4'h1)
        else $error("port activity changed off a bit tick");
    min_gap_a: assert property ($rose(any_on) && seen_r |->
        idle_r >= GAP_CYC)
        else $error("gap between packets too short");
    jam_len_a: assert property ($fell(all_on) |-> all_r >= JAM_CYC)
        else $error("jam to all ports too short");
    jam_first_a: assert property ($rose(all_on) |-> first_cell_s)
        else $error("jam does not start with a one");
    jam_alt_a: assert property (ph_r == 4'h6 && all_on &&
        $past(all_on, 10) |-> do_line[0] != $past(do_line[0], 10))
        else $error("jam bits do not alternate");
    src_excl_a: assert property (!jam_active |->
        (do_active & rx_active) == '0)
        else $error("frame repeated to its source");
endmodule
bind rcj_repeater rcj_sva #(.PORTS(PORTS)) i_rcj_sva (.clk(clk),
    .resetn(resetn), .rx_active(rx_active), .do_line(do_line),
    .do_active(do_active), .jam_active(jam_active));
